// ---- sfr_pkg.sv ----
// Constants, field masks and types for the bank-0 special register map.
package sfr_pkg;

  // File addresses of the registers (byte address on the bus is four times).
  localparam logic [7:0] ADR_INDIRECT  = 8'h00;
  localparam logic [7:0] ADR_TIMER0    = 8'h01;
  localparam logic [7:0] ADR_PCL       = 8'h02;
  localparam logic [7:0] ADR_STATUS    = 8'h03;
  localparam logic [7:0] ADR_POINTER   = 8'h04;
  localparam logic [7:0] ADR_PORT_A    = 8'h05;
  localparam logic [7:0] ADR_PORT_B    = 8'h06;
  localparam logic [7:0] ADR_PORT_C    = 8'h07;
  localparam logic [7:0] ADR_PC_BUF    = 8'h0a;
  localparam logic [7:0] ADR_INT_CTRL  = 8'h0b;
  localparam logic [7:0] ADR_PIR       = 8'h0c;
  localparam logic [7:0] ADR_T1_LOW    = 8'h0e;
  localparam logic [7:0] ADR_T1_HIGH   = 8'h0f;
  localparam logic [7:0] ADR_T1_CTRL   = 8'h10;
  localparam logic [7:0] ADR_T2_COUNT  = 8'h11;
  localparam logic [7:0] ADR_T2_CTRL   = 8'h12;
  localparam logic [7:0] ADR_SER_BUF   = 8'h13;
  localparam logic [7:0] ADR_SER_CTRL  = 8'h14;
  localparam logic [7:0] ADR_CC_LOW    = 8'h15;
  localparam logic [7:0] ADR_CC_HIGH   = 8'h16;
  localparam logic [7:0] ADR_CC_CTRL   = 8'h17;
  localparam logic [7:0] ADR_CONV_RES  = 8'h1e;
  localparam logic [7:0] ADR_CONV_CTRL = 8'h1f;
  localparam logic [7:0] ADR_SER_STAT  = 8'h94;
  localparam logic [7:0] ADR_RAM_FIRST = 8'h20;
  localparam int         RAM_DEPTH     = 96;

  // Implemented bit masks.
  localparam logic [7:0] MASK_PORT_A   = 8'h3f;
  localparam logic [7:0] MASK_PIR      = 8'h4f;
  localparam logic [7:0] MASK_T1_CTRL  = 8'h3f;
  localparam logic [7:0] MASK_T2_CTRL  = 8'h7f;
  localparam logic [7:0] MASK_CC_CTRL  = 8'h3f;
  localparam logic [7:0] MASK_CONV     = 8'hfd;
  localparam logic [7:0] MASK_PC_BUF   = 8'h1f;
  localparam logic [7:0] MASK_SER_STAT = 8'h3f;
  localparam logic [7:0] MASK_STS_WR   = 8'he7;

  // Status field positions and reset values.
  localparam int         STS_TIMEOUT   = 4;
  localparam int         STS_PWRDOWN   = 3;
  localparam logic [7:0] STATUS_POR    = 8'h18;
  localparam logic [7:0] STATUS_KEEP   = 8'h1f;
  localparam logic [7:0] INT_CTRL_KEEP = 8'h01;
  localparam logic [7:0] PERIPH_RESET  = 8'h00;
  localparam logic [7:0] CORE_RESET    = 8'h00;
  localparam int         SYNC_WIDTH    = 25;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_READ = 1'b1
  } sfr_state_t;

  // Bits that exist in a bank-0 peripheral slot; zero for core and holes.
  function automatic logic [7:0] impl_mask(input logic [7:0] a);
    case (a)
      ADR_TIMER0, ADR_PORT_B, ADR_PORT_C, ADR_T1_LOW, ADR_T1_HIGH,
      ADR_T2_COUNT, ADR_SER_BUF, ADR_SER_CTRL, ADR_CC_LOW,
      ADR_CC_HIGH, ADR_CONV_RES: impl_mask = 8'hff;
      ADR_PORT_A:    impl_mask = MASK_PORT_A;
      ADR_PIR:       impl_mask = MASK_PIR;
      ADR_T1_CTRL:   impl_mask = MASK_T1_CTRL;
      ADR_T2_CTRL:   impl_mask = MASK_T2_CTRL;
      ADR_CC_CTRL:   impl_mask = MASK_CC_CTRL;
      ADR_CONV_CTRL: impl_mask = MASK_CONV;
      default:       impl_mask = 8'h00;
    endcase
  endfunction

  // Bits that hold their contents through a pin or watchdog reset.
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      ADR_TIMER0, ADR_PORT_B, ADR_PORT_C, ADR_T1_LOW, ADR_T1_HIGH,
      ADR_SER_BUF, ADR_CC_LOW, ADR_CC_HIGH,
      ADR_CONV_RES: keep_mask = 8'hff;
      ADR_PORT_A:   keep_mask = 8'h10;
      ADR_T1_CTRL:  keep_mask = MASK_T1_CTRL;
      default:      keep_mask = 8'h00;
    endcase
  endfunction

endpackage

// ---- sfr_ram_if.sv ----
// Carrier between the register map and its general purpose data memory.
`timescale 1ns/1ps
`default_nettype none
interface sfr_ram_if;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bank (output we, output addr, output wdata, input rdata);
  modport ram  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- sfr_gpr_ram.sv ----
// General purpose data memory behind the bank-0 register map.
`timescale 1ns/1ps
`default_nettype none
module sfr_gpr_ram (
  input wire logic mclk,          // core clock
  sfr_ram_if.ram   port           // access from the register map
);

  logic [7:0] mem [0:sfr_pkg::RAM_DEPTH-1];
  logic [6:0] idx;

  // The map only addresses this memory above its first location.
  assign idx = port.addr - sfr_pkg::ADR_RAM_FIRST[6:0];
  assign port.rdata = mem[idx];

  // Static RAM: contents survive every reset and start unknown.
  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem[idx] <= port.wdata;
    end
  end

endmodule
`default_nettype wire

// ---- sfr_bank0.sv ----
// Bank-0 special function register map with an AHB-Lite register port.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module sfr_bank0 (
  input  wire logic        mclk,                 // core clock, 40 MHz
  input  wire logic        resetn,               // async power-on reset
  input  wire logic        hsel,                 // AHB slave select
  input  wire logic [31:0] haddr,                // AHB address
  input  wire logic [1:0]  htrans,               // AHB transfer type
  input  wire logic        hwrite,               // AHB write flag
  input  wire logic [2:0]  hsize,                // AHB size, word only
  input  wire logic [31:0] hwdata,               // AHB write data
  input  wire logic        hready,               // AHB bus ready
  output var  logic        hreadyout,            // AHB slave ready
  output var  logic        hresp,                // AHB response
  output var  logic [31:0] hrdata,               // AHB read data
  input  wire logic        external_reset_pin_n, // reset pin, low active
  input  wire logic        brown_out_reset_n,    // brown-out, low active
  input  wire logic        watchdog_timeout,     // watchdog expiry level
  input  wire logic        pc_step,              // core advances the PC
  input  wire logic        pc_load,              // core branches
  input  wire logic [10:0] pc_load_target,       // branch target low bits
  input  wire logic [5:0]  port_a_pins,          // port A pin levels
  input  wire logic [7:0]  port_b_pins,          // port B pin levels
  input  wire logic [7:0]  port_c_pins,          // port C pin levels
  output var  logic [12:0] program_counter,      // full program counter
  output var  logic [7:0]  status,               // status register
  output var  logic [7:0]  interrupt_control,    // interrupt control
  output var  logic [5:0]  port_a_latch,         // port A data latch
  output var  logic [7:0]  port_b_latch,         // port B data latch
  output var  logic [7:0]  port_c_latch          // port C data latch
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  sfr_ram_if ram ();

  logic [sfr_pkg::SYNC_WIDTH-1:0] sync1_r;
  logic [sfr_pkg::SYNC_WIDTH-1:0] sync2_r;
  logic                    ext_n_s;
  logic                    bor_n_s;
  logic                    wdt_s;
  logic [5:0]              pa_s;
  logic [7:0]              pb_s;
  logic [7:0]              pc_s;
  logic                    por_class;
  logic                    oth_class;

  sfr_pkg::sfr_state_t     state_r;
  logic                    hreadyout_r;
  logic                    hresp_r;
  logic [31:0]             hrdata_r;
  logic                    ahb_go;
  logic                    ahb_mapped;
  logic                    wr_pend_r;
  logic [7:0]              wr_addr_r;
  logic [7:0]              rd_addr_r;
  logic                    rd_map_r;
  logic [7:0]              wr_ea;
  logic [7:0]              rd_ea;
  logic [7:0]              wdat;
  logic [7:0]              rd_data;

  logic [7:0]              periph_r [0:31];
  logic [12:0]             pc_r;
  logic [7:0]              status_r;
  logic [7:0]              pointer_r;
  logic [4:0]              pc_buf_r;
  logic [7:0]              int_ctrl_r;
  logic [5:0]              ser_stat_r;

  logic                    wr_pcl;
  logic                    wr_status;
  logic                    wr_pointer;
  logic                    wr_pc_buf;
  logic                    wr_int_ctrl;
  logic                    wr_ser_stat;
  logic                    wr_periph;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Core registers are matched on the low seven bits so both banks hit.
  function automatic logic core_hit(input logic [7:0] ea,
                                    input logic [7:0] off);
    core_hit = (ea[6:0] == off[6:0]);
  endfunction

  function automatic logic [7:0] resolve(input logic [7:0] a,
                                         input logic [7:0] ptr);
    resolve = core_hit(a, sfr_pkg::ADR_INDIRECT) ? ptr : a;
  endfunction

  function automatic logic ram_hit(input logic [7:0] ea);
    ram_hit = !ea[7] && (ea >= sfr_pkg::ADR_RAM_FIRST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reset classes.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= {2'b11, 23'h000000};
      sync2_r <= {2'b11, 23'h000000};
    end else begin
      sync1_r <= {external_reset_pin_n, brown_out_reset_n, watchdog_timeout,
                  port_a_pins, port_b_pins, port_c_pins};
      sync2_r <= sync1_r;
    end
  end

  assign {ext_n_s, bor_n_s, wdt_s, pa_s, pb_s, pc_s} = sync2_r;

  assign por_class = !bor_n_s;
  assign oth_class = !ext_n_s || wdt_s;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Writes take no wait state; reads take one, so a read
  // right behind a write always sees the stored result.

  assign ahb_go     = hsel && htrans[1] && hready;
  assign ahb_mapped = (haddr[31:10] == 22'h000000);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_go && hwrite && ahb_mapped;
      if (ahb_go) begin
        wr_addr_r <= haddr[9:2];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= sfr_pkg::ST_IDLE;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      hrdata_r    <= 32'h00000000;
      rd_addr_r   <= 8'h00;
      rd_map_r    <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      unique case (state_r)
        sfr_pkg::ST_IDLE: begin
          if (ahb_go && !hwrite) begin
            state_r     <= sfr_pkg::ST_READ;
            hreadyout_r <= 1'b0;
            rd_addr_r   <= haddr[9:2];
            rd_map_r    <= ahb_mapped;
          end
        end
        sfr_pkg::ST_READ: begin
          state_r     <= sfr_pkg::ST_IDLE;
          hreadyout_r <= 1'b1;
          hrdata_r    <= {24'h000000, rd_data};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.

  assign wr_ea = resolve(wr_addr_r, pointer_r);
  assign rd_ea = resolve(rd_addr_r, pointer_r);
  assign wdat  = hwdata[7:0];

  assign wr_pcl      = wr_pend_r && core_hit(wr_ea, sfr_pkg::ADR_PCL);
  assign wr_status   = wr_pend_r && core_hit(wr_ea, sfr_pkg::ADR_STATUS);
  assign wr_pointer  = wr_pend_r && core_hit(wr_ea, sfr_pkg::ADR_POINTER);
  assign wr_pc_buf   = wr_pend_r && core_hit(wr_ea, sfr_pkg::ADR_PC_BUF);
  assign wr_int_ctrl = wr_pend_r && core_hit(wr_ea, sfr_pkg::ADR_INT_CTRL);
  assign wr_ser_stat = wr_pend_r && (wr_ea == sfr_pkg::ADR_SER_STAT);
  // holes and core slots drop writes
  assign wr_periph   = wr_pend_r && (wr_ea[7:5] == 3'b000) &&
                       (sfr_pkg::impl_mask(wr_ea) != 8'h00);

  assign ram.we    = wr_pend_r && ram_hit(wr_ea);
  assign ram.addr  = wr_pend_r ? wr_ea[6:0] : rd_ea[6:0];
  assign ram.wdata = wdat;

  sfr_gpr_ram u_ram (
    .mclk (mclk),
    .port (ram)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral register slots of bank 0.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        periph_r[i] <= sfr_pkg::PERIPH_RESET;
      end
    end else if (por_class) begin
      for (int i = 0; i < 32; i++) begin
        periph_r[i] <= sfr_pkg::PERIPH_RESET;
      end
    end else if (oth_class) begin
      for (int i = 0; i < 32; i++) begin
        periph_r[i] <= periph_r[i] & sfr_pkg::keep_mask(8'(i));
      end
    end else if (wr_periph) begin
      periph_r[wr_ea[4:0]] <= wdat & sfr_pkg::impl_mask(wr_ea);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and its upper buffer.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_buf_r <= 5'h00;
    end else if (por_class || oth_class) begin
      pc_buf_r <= 5'h00;
    end else if (wr_pc_buf) begin
      pc_buf_r <= wdat[4:0] & sfr_pkg::MASK_PC_BUF[4:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= 13'h0000;
    end else if (por_class || oth_class) begin
      pc_r <= 13'h0000;
    end else if (wr_pcl) begin
      pc_r <= {pc_buf_r, wdat};
    end else if (pc_load) begin
      pc_r <= {pc_buf_r[4:3], pc_load_target};
    end else if (pc_step) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, pointer, interrupt control and serial port status.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_r <= sfr_pkg::STATUS_POR;
    end else if (por_class) begin
      status_r <= sfr_pkg::STATUS_POR;
    end else if (oth_class) begin
      status_r <= status_r & sfr_pkg::STATUS_KEEP;
      if (wdt_s) begin
        status_r[sfr_pkg::STS_TIMEOUT] <= 1'b0;
      end
    end else if (wr_status) begin
      // Timeout and power-down flags are owned by hardware only. The
      // reserved bank-select bits are stored as written; software keeps
      // them clear.
      status_r <= (status_r & ~sfr_pkg::MASK_STS_WR) |
                  (wdat & sfr_pkg::MASK_STS_WR);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pointer_r <= sfr_pkg::CORE_RESET;
    end else if (por_class) begin
      pointer_r <= sfr_pkg::CORE_RESET;
    end else if (wr_pointer && !oth_class) begin
      pointer_r <= wdat;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      int_ctrl_r <= sfr_pkg::CORE_RESET;
    end else if (por_class) begin
      int_ctrl_r <= sfr_pkg::CORE_RESET;
    end else if (oth_class) begin
      int_ctrl_r <= int_ctrl_r & sfr_pkg::INT_CTRL_KEEP;
    end else if (wr_int_ctrl) begin
      int_ctrl_r <= wdat;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ser_stat_r <= 6'h00;
    end else if (por_class || oth_class) begin
      ser_stat_r <= 6'h00;
    end else if (wr_ser_stat) begin
      ser_stat_r <= wdat[5:0] & sfr_pkg::MASK_SER_STAT[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  always_comb begin
    rd_data = 8'h00;
    if (rd_map_r) begin
      case (rd_ea[6:0])
        sfr_pkg::ADR_PCL[6:0]:      rd_data = pc_r[7:0];
        sfr_pkg::ADR_STATUS[6:0]:   rd_data = status_r;
        sfr_pkg::ADR_POINTER[6:0]:  rd_data = pointer_r;
        sfr_pkg::ADR_PC_BUF[6:0]:   rd_data = {3'b000, pc_buf_r};
        sfr_pkg::ADR_INT_CTRL[6:0]: rd_data = int_ctrl_r;
        default: begin
          if (rd_ea == sfr_pkg::ADR_SER_STAT) begin
            rd_data = {2'b00, ser_stat_r};
          end else if (rd_ea[7:5] == 3'b000) begin
            // Ports return pin levels; the latch is write-only.
            case (rd_ea)
              sfr_pkg::ADR_PORT_A: rd_data = {2'b00, pa_s};
              sfr_pkg::ADR_PORT_B: rd_data = pb_s;
              sfr_pkg::ADR_PORT_C: rd_data = pc_s;
              default: rd_data = periph_r[rd_ea[4:0]] &
                                 sfr_pkg::impl_mask(rd_ea);
            endcase
          end else if (ram_hit(rd_ea)) begin
            rd_data = ram.rdata;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hreadyout         = hreadyout_r;
  assign hresp             = hresp_r;
  assign hrdata            = hrdata_r;
  assign program_counter   = pc_r;
  assign status            = status_r;
  assign interrupt_control = int_ctrl_r;
  assign port_a_latch      = periph_r[5][5:0];
  assign port_b_latch      = periph_r[6];
  assign port_c_latch      = periph_r[7];

endmodule
`default_nettype wire

// ---- sfr_core_model.sv ----
// Core-side model issuing file register reads and writes over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sfr_core_model (
  input  wire logic        mclk,    // core clock
  input  wire logic        hready,  // bus ready from the slave
  input  wire logic [31:0] hrdata,  // read data from the slave
  output var  logic        hsel,    // slave select
  output var  logic [31:0] haddr,   // byte address
  output var  logic [1:0]  htrans,  // transfer type
  output var  logic        hwrite,  // write flag
  output var  logic [2:0]  hsize,   // always one word
  output var  logic [31:0] hwdata   // write data
);
  int hangs = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] d;
    int n;
    d = wd;
    if ((a[9:2] & 8'h7f) == sfr_pkg::ADR_STATUS) d = wd & 8'h3f;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    n = 0;
    do begin @(posedge mclk); n++; end while (!hready && n < 100);
    if (n >= 100) hangs++;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    n = 0;
    do begin @(posedge mclk); n++; end while (!hready && n < 100);
    if (n >= 100) hangs++;
    rd = hrdata[7:0];
  endtask
endmodule
`default_nettype wire

// ---- sfr_bank0_monitor.sv ----
// Concurrent checks on the ports of the bank-0 register map.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_monitor (
  input wire logic        mclk,                 // core clock
  input wire logic        resetn,               // power-on reset
  input wire logic        hsel,                 // slave select
  input wire logic [31:0] haddr,                // byte address
  input wire logic [1:0]  htrans,               // transfer type
  input wire logic        hwrite,               // write flag
  input wire logic        hready,               // bus ready
  input wire logic        hreadyout,            // slave ready
  input wire logic        hresp,                // response
  input wire logic [31:0] hrdata,               // read data
  input wire logic        external_reset_pin_n, // pin reset
  input wire logic        brown_out_reset_n,    // brown-out reset
  input wire logic        watchdog_timeout,     // watchdog reset
  input wire logic        pc_step,              // counter advance
  input wire logic        pc_load,              // branch
  input wire logic [10:0] pc_load_target,       // branch target
  input wire logic [12:0] program_counter,      // full counter
  input wire logic [7:0]  status,               // status register
  input wire logic [7:0]  interrupt_control     // interrupt control
);
  logic       wr_ph_r;
  logic [2:0] quiet_r;
  wire        take = hsel && htrans[1] && hready;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) wr_ph_r <= 1'b0;
    else wr_ph_r <= take && hwrite;
  end
  // Class resets reach the map late, so the counter checks wait them out.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) quiet_r <= 3'd0;
    else if (!external_reset_pin_n || !brown_out_reset_n || watchdog_timeout)
      quiet_r <= 3'd0;
    else if (quiet_r != 3'd4) quiet_r <= quiet_r + 3'd1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence rd_any;
    take && !hwrite;
  endsequence
  sequence rd_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_one_wait: assert property (rd_any |=> rd_done)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_upper_zero: assert property (rd_any |=> ##1 hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ser_top_zero: assert property (rd_any ##0 haddr == 32'h250
    |=> ##1 hrdata[7:6] == 2'b00) else $error("serial status top set");
  a_hole_zero: assert property (rd_any ##0 (haddr[31:10] != 22'h0
    || haddr[9:2] inside {8'h08, 8'h09, 8'h0d, 8'h18, 8'h1d, 8'h95})
    |=> ##1 hrdata == 32'h0) else $error("hole read not zero");
  a_pc_branch: assert property (pc_load && !wr_ph_r && quiet_r == 3'd4
    |=> program_counter[10:0] == $past(pc_load_target))
    else $error("branch target not loaded");
  a_pc_advance: assert property (pc_step && !pc_load && !wr_ph_r
    && quiet_r == 3'd4 |=> program_counter == $past(program_counter) + 13'd1)
    else $error("counter did not advance");
  a_release_vals: assert property ($rose(resetn) |->
    status == sfr_pkg::STATUS_POR && program_counter == 13'h0)
    else $error("values after reset wrong");
  a_power_class: assert property (!brown_out_reset_n [*4] |->
    status == sfr_pkg::STATUS_POR && interrupt_control == 8'h00)
    else $error("brown-out class values wrong");
  a_pin_class: assert property (!external_reset_pin_n [*5] |->
    program_counter == 13'h0 && $stable(status[4:3]))
    else $error("pin class values wrong");
  a_wdt_timeout: assert property (watchdog_timeout [*5] |->
    !status[sfr_pkg::STS_TIMEOUT] && program_counter == 13'h0)
    else $error("watchdog class values wrong");
endmodule
bind sfr_bank0 sfr_bank0_monitor i_mon (.mclk, .resetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .external_reset_pin_n, .brown_out_reset_n, .watchdog_timeout, .pc_step,
  .pc_load, .pc_load_target, .program_counter, .status, .interrupt_control);
`default_nettype wire

// ---- sfr_bank0_tb.sv ----
// Self-checking bench for the bank-0 register map.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_tb;
  logic mclk = 1'b0, resetn = 1'b0, ext_n = 1'b1, bor_n = 1'b1, wdt = 1'b0;
  logic pc_step = 1'b0, pc_load = 1'b0;
  logic [10:0] tgt = 11'h0;
  logic [5:0] pa = 6'h0;
  logic [7:0] pb = 8'h0, pcp = 8'h0, rv, p, lat_c, lat_b, st, ic;
  logic [5:0] lat_a;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, seed = 32'hdd022cec;
  logic [12:0] pcv;
  logic [7:0] m [10];
  int error_cnt = 0, n_checks = 0, i;
  localparam logic [7:0] RA [10] = '{sfr_pkg::ADR_POINTER,
    sfr_pkg::ADR_PC_BUF, sfr_pkg::ADR_INT_CTRL, sfr_pkg::ADR_PIR,
    sfr_pkg::ADR_T1_CTRL, sfr_pkg::ADR_T2_CTRL, sfr_pkg::ADR_SER_BUF,
    sfr_pkg::ADR_CC_CTRL, sfr_pkg::ADR_CONV_CTRL, sfr_pkg::ADR_SER_STAT};
  localparam logic [7:0] RM [10] = '{8'hff, sfr_pkg::MASK_PC_BUF, 8'hff,
    sfr_pkg::MASK_PIR, sfr_pkg::MASK_T1_CTRL, sfr_pkg::MASK_T2_CTRL, 8'hff,
    sfr_pkg::MASK_CC_CTRL, sfr_pkg::MASK_CONV, sfr_pkg::MASK_SER_STAT};
  localparam logic [7:0] KP [10] = '{8'hff, 8'h00, 8'h01, 8'h00,
    sfr_pkg::MASK_T1_CTRL, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] HOLE [6] = '{8'h08, 8'h09, 8'h0d, 8'h18, 8'h1d,
    8'h95};
  always #12.5 mclk = ~mclk;
  sfr_bank0 i_sfr_bank0 (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .external_reset_pin_n(ext_n),
    .brown_out_reset_n(bor_n), .watchdog_timeout(wdt), .pc_step(pc_step),
    .pc_load(pc_load), .pc_load_target(tgt), .port_a_pins(pa),
    .port_b_pins(pb), .port_c_pins(pcp), .program_counter(pcv),
    .status(st), .interrupt_control(ic), .port_a_latch(lat_a),
    .port_b_latch(lat_b), .port_c_latch(lat_c));
  sfr_core_model i_sfr_core_model (.mclk(mclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] fa, input logic [7:0] d);
    i_sfr_core_model.xfer(1'b1, {22'h0, fa, 2'b00}, d, rv);
  endtask
  task automatic rdc(input logic [7:0] fa, input logic [7:0] exp);
    i_sfr_core_model.xfer(1'b0, {22'h0, fa, 2'b00}, 8'h00, rv);
    chk({5'h0, rv}, {5'h0, exp}, "read");
  endtask
  task automatic hold_reset(input int which);
    if (which == 0) ext_n <= 1'b0;
    if (which == 1) wdt <= 1'b1;
    if (which == 2) bor_n <= 1'b0;
    repeat (5) @(posedge mclk);
    ext_n <= 1'b1;
    wdt <= 1'b0;
    bor_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic summarize();
    error_cnt += i_sfr_core_model.hangs;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 10; i++) rdc(RA[i], 8'h00);
    rdc(sfr_pkg::ADR_STATUS, sfr_pkg::STATUS_POR);
    for (i = 0; i < 10; i++) begin
      seed = xs(seed);
      m[i] = seed[7:0] & RM[i];
      wr(RA[i], seed[7:0]);
    end
    for (i = 0; i < 10; i++) rdc(RA[i], m[i]);
    for (i = 0; i < 3; i++) rdc(RA[i] | 8'h80, m[i]);
    chk({5'h0, ic}, {5'h0, m[2]}, "intctrl port");
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr(HOLE[i], seed[7:0]);
      rdc(HOLE[i], 8'h00);
    end
    i_sfr_core_model.xfer(1'b1, 32'h410, 8'h5a, rv);
    i_sfr_core_model.xfer(1'b0, 32'h410, 8'h00, rv);
    chk({5'h0, rv}, 13'h0, "unmapped");
    rdc(sfr_pkg::ADR_POINTER, m[0]);
    seed = xs(seed);
    p = sfr_pkg::ADR_RAM_FIRST + 8'(seed % 32'd96);
    wr(sfr_pkg::ADR_POINTER, p);
    wr(sfr_pkg::ADR_INDIRECT, seed[15:8]);
    rdc(8'h80, seed[15:8]);
    wr(sfr_pkg::ADR_POINTER, sfr_pkg::ADR_T2_CTRL);
    wr(sfr_pkg::ADR_INDIRECT, 8'hff);
    m[5] = sfr_pkg::MASK_T2_CTRL;
    rdc(sfr_pkg::ADR_T2_CTRL, m[5]);
    wr(sfr_pkg::ADR_POINTER, 8'h00);
    m[0] = 8'h00;
    rdc(sfr_pkg::ADR_INDIRECT, 8'h00);
    wr(sfr_pkg::ADR_PC_BUF, 8'hff);
    m[1] = sfr_pkg::MASK_PC_BUF;
    tgt <= seed[26:16];
    pc_load <= 1'b1;
    @(posedge mclk);
    pc_load <= 1'b0;
    #1 chk(pcv, {2'b11, seed[26:16]}, "branch");
    wr(sfr_pkg::ADR_PCL, 8'hff);
    #1 chk(pcv, 13'h1fff, "pcl write");
    pc_step <= 1'b1;
    @(posedge mclk);
    pc_step <= 1'b0;
    #1 chk(pcv, 13'h0000, "wrap");
    wr(sfr_pkg::ADR_STATUS, 8'he5);
    rdc(sfr_pkg::ADR_STATUS, 8'h3d);
    seed = xs(seed);
    pa <= seed[5:0];
    pb <= seed[15:8];
    repeat (3) @(posedge mclk);
    rdc(sfr_pkg::ADR_PORT_A, {2'b00, seed[5:0]});
    rdc(sfr_pkg::ADR_PORT_B, seed[15:8]);
    wr(sfr_pkg::ADR_PORT_C, seed[31:24]);
    #1 chk({5'h0, lat_c}, {5'h0, seed[31:24]}, "latch");
    wr(sfr_pkg::ADR_PORT_A, seed[7:0]);
    #1 chk({7'h0, lat_a}, {7'h0, seed[5:0]}, "latch a");
    wr(sfr_pkg::ADR_PORT_B, seed[23:16]);
    #1 chk({5'h0, lat_b}, {5'h0, seed[23:16]}, "latch b");
    wr(sfr_pkg::ADR_PCL, 8'h12);
    #1 chk(pcv, 13'h1f12, "pcl write");
    hold_reset(0);
    chk(pcv, 13'h0, "pin pc");
    for (i = 0; i < 10; i++) begin
      m[i] = m[i] & KP[i];
      rdc(RA[i], m[i]);
    end
    rdc(sfr_pkg::ADR_STATUS, 8'h1d);
    hold_reset(1);
    rdc(sfr_pkg::ADR_STATUS, 8'h0d);
    hold_reset(2);
    for (i = 0; i < 10; i++) rdc(RA[i], 8'h00);
    rdc(sfr_pkg::ADR_STATUS, sfr_pkg::STATUS_POR);
    summarize();
  end
endmodule
`default_nettype wire
